// file: rtl/dacc_capture_compare.sv
// dual capture/compare register arrays with four reloadable timers
`timescale 1ns/100ps

module dacc_capture_compare
  import dacc_pkg::*;
#(
  parameter int TW = TMR_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  wrEn,
  input  wire logic [5:0]            wrAddr,
  input  wire logic [TW-1:0]         wrData,
  input  wire logic [CC_CNT*3-1:0]   ccModeFlat,
  input  wire logic [CC_CNT-1:0]     ccTimerSel,
  input  wire logic [CC_CNT*2-1:0]   ccEdgeFlat,
  input  wire logic [CC_CNT-1:0]     ccSingle,
  input  wire logic [TMR_CNT-1:0]    tmrRun,
  input  wire logic [TMR_CNT*2-1:0]  tmrSrcFlat,
  input  wire logic [TMR_CNT*3-1:0]  tmrPreFlat,
  input  wire logic                  staggered,
  input  wire logic                  extTimebaseEv,
  input  wire logic [CNT_PINS-1:0]   countPinIn,
  input  wire logic [PIN_CNT-1:0]    ccPinIn,
  output logic      [PIN_CNT-1:0]    ccPinOut,
  output logic      [PIN_CNT-1:0]    ccPinOe,
  output logic      [CC_CNT-1:0]     ccIrq,
  output logic      [CC_CNT*TW-1:0]  ccValueFlat,
  output logic      [TMR_CNT*TW-1:0] tmrValueFlat,
  output logic      [TMR_CNT-1:0]    tmrOvf
);

  ////////////////////////////////////////////////////////////////////
  // declarations

  localparam int SYN_W = PIN_CNT + CNT_PINS;

  logic [SYN_W-1:0]   syn1_r;          // first stage, read by syn2 only
  logic [SYN_W-1:0]   syn2_r;
  logic [SYN_W-1:0]   syn3_r;
  logic [SYN_W-1:0]   synLvl_r;        // filtered pin level
  logic [SYN_W-1:0]   synAgree;        // second and third stages agree
  logic [SYN_W-1:0]   pinRise;         // filtered rising edge
  logic [SYN_W-1:0]   pinFall;         // filtered falling edge

  logic [PRE_W-1:0]   preCnt_r;        // shared free-running prescaler

  logic [TW-1:0]      tmrVal_r [TMR_CNT];
  logic [TW-1:0]      reload_r [TMR_CNT];
  logic [TMR_CNT-1:0] tmrTickd_r;      // timer took a new count value
  logic [TMR_CNT-1:0] tmrOvf_r;        // timer wrapped and reloaded

  logic [TW-1:0]      ccVal_r [CC_CNT];
  logic [CC_CNT-1:0]  ccIrq_r;
  logic [CC_CNT-1:0]  armed_r;         // once-per-period modes may fire
  logic [CC_CNT-1:0]  done_r;          // single event already spent
  logic [CC_CNT-1:0]  matchEv;         // compare event this cycle
  logic [CC_CNT-1:0]  isDouble;        // register in double mode

  logic [PIN_CNT-1:0] pinLvl_r;
  logic [PIN_CNT-1:0] pinOe_r;

  ////////////////////////////////////////////////////////////////////
  // pin input conditioning

  // three-stage synchroniser on every external pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      syn1_r <= '0;
      syn2_r <= '0;
      syn3_r <= '0;
    end else begin
      syn1_r <= {countPinIn, ccPinIn};
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
    end
  end

  // a change only counts once the later two stages agree
  assign synAgree = ~(syn2_r ^ syn3_r);

  // filtered level follows agreed value
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      synLvl_r <= '0;
    end else begin
      synLvl_r <= (synAgree & syn3_r) | (~synAgree & synLvl_r);
    end
  end

  // edges of the filtered level
  assign pinRise = synAgree & syn3_r & ~synLvl_r;
  assign pinFall = synAgree & ~syn3_r & synLvl_r;

  ////////////////////////////////////////////////////////////////////
  // prescaler

  // free counter; each timer taps its own divide ratio
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      preCnt_r <= '0;
    end else begin
      preCnt_r <= preCnt_r + PRE_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timers

  for (genvar t = 0; t < TMR_CNT; t++) begin : g_tmr
    logic [2:0] preRaw;                // requested divide select
    logic [2:0] preSel;                // after staggered floor
    logic [7:0] preMask;               // low prescaler bits to match
    logic       preHit;                // prescaled enable pulse
    logic       srcEv;                 // selected count event
    logic       tick;                  // timer advances this cycle
    logic       wrTmr;                 // software loads timer
    logic       wrRel;                 // software loads reload value
    dacc_src_t  src;

    assign preRaw = tmrPreFlat[t*3 +: 3];
    assign src    = dacc_src_t'(tmrSrcFlat[t*2 +: 2]);
    assign preSel = (staggered && preRaw < STAGGER_MIN_PRE) ? STAGGER_MIN_PRE : preRaw;
    // full rate when select is zero
    assign preMask = (8'h01 << preSel) - 8'h01;
    assign preHit  = (preCnt_r & preMask[PRE_W-1:0]) == preMask[PRE_W-1:0];

    always_comb begin
      srcEv = 1'b0;
      unique case (src)
        SRC_PRESCALE: srcEv = preHit;
        SRC_TIMEBASE: srcEv = extTimebaseEv;
        // count pin only on even timers 0 and 2
        SRC_COUNTPIN: srcEv = (t % 2 == 0) && pinRise[PIN_CNT + t / 2];
        default:      srcEv = 1'b0;   // unused code stops the timer
      endcase
    end

    assign tick  = tmrRun[t] && srcEv;
    assign wrTmr = wrEn && wrAddr == ADDR_TIMER_BASE + 6'(t);
    assign wrRel = wrEn && wrAddr == ADDR_RELOAD_BASE + 6'(t);

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        reload_r[t] <= '0;
      end else if (wrRel) begin
        reload_r[t] <= wrData;
      end
    end

    // timer counts up on its enable
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        tmrVal_r[t]   <= '0;
        tmrTickd_r[t] <= 1'b0;
        tmrOvf_r[t]   <= 1'b0;
      end else begin
        // a software load is not a count step, so no match from it
        tmrTickd_r[t] <= tick && !wrTmr;
        tmrOvf_r[t]   <= 1'b0;
        if (wrTmr) begin
          tmrVal_r[t] <= wrData;
        end else if (tick) begin
          if (&tmrVal_r[t]) begin
            tmrVal_r[t] <= reload_r[t];
            tmrOvf_r[t] <= 1'b1;
          end else begin
            tmrVal_r[t] <= tmrVal_r[t] + TW'(1);
          end
        end
      end
    end

    assign tmrValueFlat[t*TW +: TW] = tmrVal_r[t];
  end

  assign tmrOvf = tmrOvf_r;

  ////////////////////////////////////////////////////////////////////
  // capture/compare registers

  for (genvar i = 0; i < CC_CNT; i++) begin : g_cc
    localparam bit ARR = (i >= CC_PER_ARRAY);
    dacc_mode_t  mode;
    logic [1:0]  tIdx;                 // global timer number
    logic        isCmp;                // any of the five compare modes
    logic        onceMode;             // one event per period
    logic        hit;                  // timer equals register
    logic        armedNow;             // armed, counting a fresh wrap
    logic        capEv;                // capture trigger this cycle
    logic        wrReg;                // software writes register

    assign mode = dacc_mode_t'(ccModeFlat[i*3 +: 3]);
    assign tIdx = {ARR, ccTimerSel[i]};
    assign isCmp = mode == MODE_CMP0 || mode == MODE_CMP1 || mode == MODE_CMP2
                || mode == MODE_CMP3 || mode == MODE_DOUBLE;
    assign onceMode = mode == MODE_CMP2 || mode == MODE_CMP3;
    assign isDouble[i] = mode == MODE_DOUBLE;
    assign wrReg = wrEn && wrAddr == 6'(i);

    assign hit = tmrTickd_r[tIdx] && tmrVal_r[tIdx] == ccVal_r[i];
    // a match on the reload value belongs to the new period
    assign armedNow = armed_r[i] || tmrOvf_r[tIdx];
    assign matchEv[i] = isCmp && hit && (!onceMode || armedNow)
                     && !(ccSingle[i] && done_r[i]);

    if (i >= PIN_BASE && i < PIN_BASE + PIN_CNT) begin : g_cap
      assign capEv = mode == MODE_CAPTURE
          && ((ccEdgeFlat[i*2 + EDGE_RISE_BIT] && pinRise[i - PIN_BASE])
           || (ccEdgeFlat[i*2 + EDGE_FALL_BIT] && pinFall[i - PIN_BASE]));
    end else begin : g_nocap
      assign capEv = 1'b0;
    end

    // register contents; capture beats a same-cycle write
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        ccVal_r[i] <= '0;
      end else if (capEv) begin
        ccVal_r[i] <= tmrVal_r[tIdx];
      end else if (wrReg) begin
        ccVal_r[i] <= wrData;
      end
    end

    // one-cycle request per event
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        ccIrq_r[i] <= 1'b0;
      end else begin
        // capture or compare interrupt, repeatable in mode 0
        ccIrq_r[i] <= capEv || matchEv[i];
      end
    end

    // period gate; a fresh wrap rearms
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        armed_r[i] <= 1'b1;
      end else if (matchEv[i] && onceMode) begin
        armed_r[i] <= 1'b0;
      end else if (tmrOvf_r[tIdx]) begin
        armed_r[i] <= 1'b1;
      end
    end

    // single event spent flag; rewriting the register rearms it
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        done_r[i] <= 1'b0;
      end else if (matchEv[i] && ccSingle[i]) begin
        done_r[i] <= 1'b1;
      end else if (wrReg) begin
        done_r[i] <= 1'b0;
      end
    end

    assign ccValueFlat[i*TW +: TW] = ccVal_r[i];
  end

  assign ccIrq = ccIrq_r;

  ////////////////////////////////////////////////////////////////////
  // compare output pins

  for (genvar p = 0; p < PIN_CNT; p++) begin : g_pin
    localparam int R = PIN_BASE + p;
    dacc_mode_t mode;
    logic       ownTog;                // own match toggles pin
    logic       partTog;               // partner match toggles pin
    logic       partDbl;               // partner drives this pin
    logic       ovf;                   // own timer wrapped

    assign mode = dacc_mode_t'(ccModeFlat[R*3 +: 3]);
    assign ovf  = tmrOvf_r[{1'b1, ccTimerSel[R]}];
    assign ownTog = matchEv[R] && (mode == MODE_CMP1 || mode == MODE_DOUBLE);

    // only the lower eight have a partner register
    if (p < PAIR_OFFSET) begin : g_pair
      assign partDbl = isDouble[R + PAIR_OFFSET];
      assign partTog = matchEv[R + PAIR_OFFSET] && partDbl;
    end else begin : g_nopair
      assign partDbl = 1'b0;
      assign partTog = 1'b0;
    end

    // pin drive enable from function select
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pinOe_r[p] <= 1'b0;
      end else begin
        // pin drives in pin compare modes or when its partner is in double mode
        pinOe_r[p] <= mode == MODE_CMP1 || mode == MODE_CMP3
                   || mode == MODE_DOUBLE || partDbl;
      end
    end

    // pin level; matches of both partners together cancel out
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pinLvl_r[p] <= 1'b0;
      end else if (mode == MODE_CMP3) begin
        if (matchEv[R]) begin
          pinLvl_r[p] <= 1'b1;
        end else if (ovf) begin
          pinLvl_r[p] <= 1'b0;
        end
      end else begin
        pinLvl_r[p] <= pinLvl_r[p] ^ ownTog ^ partTog;
      end
    end
  end

  assign ccPinOut = pinLvl_r;
  assign ccPinOe  = pinOe_r;

endmodule

// file: rtl/dacc_pkg.sv
// shared constants and types for the dual array capture/compare unit
package dacc_pkg;

  // register arrays
  localparam int ARR_CNT      = 2;
  localparam int CC_PER_ARRAY = 16;
  localparam int CC_CNT       = ARR_CNT * CC_PER_ARRAY;
  localparam int TMR_CNT      = 4;
  localparam int TMR_W        = 16;

  // pins: array two registers 0..11 own one pin each
  localparam int PIN_CNT  = 12;
  localparam int PIN_BASE = 16;
  localparam int CNT_PINS = 2;

  // double-register partner sits this far above its pin owner
  localparam int PAIR_OFFSET = 8;

  // software write port map
  localparam logic [5:0] ADDR_RELOAD_BASE = 6'h20;
  localparam logic [5:0] ADDR_TIMER_BASE  = 6'h28;

  // edge select field bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  // prescaler: divide by two to the power of the select
  localparam int         PRE_W           = 7;
  localparam logic [2:0] STAGGER_MIN_PRE = 3'h3;

  // per-register function
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_CAPTURE,
    MODE_CMP0,
    MODE_CMP1,
    MODE_CMP2,
    MODE_CMP3,
    MODE_DOUBLE
  } dacc_mode_t;

  // timer count source
  typedef enum logic [1:0] {
    SRC_PRESCALE,
    SRC_TIMEBASE,
    SRC_COUNTPIN
  } dacc_src_t;

endpackage

// file: tb/dacc_capture_compare_assertions.sv
// assertion checker for the dual array capture/compare unit
`timescale 1ns/100ps

module dacc_capture_compare_assertions
  import dacc_pkg::*;
#(
  parameter int TW = TMR_W
) (
  input wire logic                  ref_clk,
  input wire logic                  reset,
  input wire logic                  wrEn,
  input wire logic [CC_CNT*3-1:0]   ccModeFlat,
  input wire logic [CC_CNT-1:0]     ccTimerSel,
  input wire logic [CC_CNT-1:0]     ccSingle,
  input wire logic [PIN_CNT-1:0]    ccPinOut,
  input wire logic [PIN_CNT-1:0]    ccPinOe,
  input wire logic [CC_CNT-1:0]     ccIrq,
  input wire logic [CC_CNT*TW-1:0]  ccValueFlat,
  input wire logic [TMR_CNT*TW-1:0] tmrValueFlat,
  input wire logic [TMR_CNT-1:0]    tmrOvf
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  logic       ovfDly_r;  // timer zero wrap pulse, one cycle late
  logic       seen_r;    // register zero already fired in this period
  // a match on the reloaded value lands one cycle after the wrap pulse
  always_ff @(posedge ref_clk) begin
    ovfDly_r <= reset ? 1'b0 : tmrOvf[0];
    seen_r   <= (reset || ccModeFlat[2:0] != MODE_CMP2) ? 1'b0
              : (ccIrq[0] | (seen_r & ~ovfDly_r));
  end
  // register one hits its timer by a count step
  sequence hitReg1;
    $changed(tmrValueFlat[15:0]) && !$past(wrEn) && !ccTimerSel[1] && !ccSingle[1]
      && ccModeFlat[5:3] == MODE_CMP0 && tmrValueFlat[15:0] == ccValueFlat[31:16];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_wrap_from_max: assert property (
    tmrOvf[0] |-> $past(tmrValueFlat[15:0]) == 16'hffff)
    else $error("wrap without maximum count");
  chk_count_step: assert property (
    $changed(tmrValueFlat[15:0]) && !tmrOvf[0] && !$past(wrEn) && !$past(reset)
      |-> tmrValueFlat[15:0] == $past(tmrValueFlat[15:0]) + 16'h1)
    else $error("timer moved by other than one");
  chk_mode0_irq: assert property (hitReg1 |-> ##1 ccIrq[1])
    else $error("interrupt-only match gave no request");
  chk_period_once: assert property (
    ccIrq[0] && ccModeFlat[2:0] == MODE_CMP2 |-> !seen_r || ovfDly_r)
    else $error("second request in one period");
  chk_toggle_pin: assert property (
    ccIrq[16] && ccModeFlat[50:48] == MODE_CMP1 && ccModeFlat[74:72] != MODE_DOUBLE
      |-> ccPinOut[0] != $past(ccPinOut[0]))
    else $error("toggle mode pin did not flip");
  chk_set_on_match: assert property (
    ccIrq[18] && ccModeFlat[56:54] == MODE_CMP3 |-> ccPinOut[2])
    else $error("set mode pin not high on match");
  chk_clear_on_wrap: assert property (
    tmrOvf[2] && ccModeFlat[56:54] == MODE_CMP3 && !ccTimerSel[18]
      |=> !ccPinOut[2] || ccIrq[18])
    else $error("set mode pin not cleared on wrap");
  chk_pin_driven: assert property (
    ccModeFlat[50:48] inside {MODE_CMP1, MODE_CMP3, MODE_DOUBLE}
      && $stable(ccModeFlat[50:48]) && !$past(reset) |-> ccPinOe[0])
    else $error("compare pin not driven");
  chk_capture_value: assert property (
    ccIrq[17] && ccModeFlat[53:51] == MODE_CAPTURE && !ccTimerSel[17]
      |-> ccValueFlat[287:272] == $past(tmrValueFlat[47:32]))
    else $error("capture latched wrong timer value");
endmodule

bind dacc_capture_compare dacc_capture_compare_assertions #(.TW(TW)) u_dacc_chk (
  .ref_clk, .reset, .wrEn, .ccModeFlat, .ccTimerSel, .ccSingle,
  .ccPinOut, .ccPinOe, .ccIrq, .ccValueFlat, .tmrValueFlat, .tmrOvf
);

// file: tb/dacc_pin_model.sv
// pin partner: outside levels on capture and count pins
`timescale 1ns/100ps

module dacc_pin_model
  import dacc_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic [PIN_CNT-1:0]  ccPinOut,
  input  wire logic [PIN_CNT-1:0]  ccPinOe,
  output logic      [PIN_CNT-1:0]  ccPinIn,
  output logic      [CNT_PINS-1:0] countPinIn
);
  logic [PIN_CNT-1:0] extLvl = '0;  // level the outside world drives
  // a pin the unit drives reads back the unit's own level
  assign ccPinIn = (ccPinOe & ccPinOut) | (~ccPinOe & extLvl);
  initial countPinIn = '0;
  // hold each level long enough to pass the input filter
  task automatic setPin(input int idx, input logic lvl);
    @(posedge ref_clk);
    extLvl[idx] <= lvl;
    repeat (8) @(posedge ref_clk);
  endtask
  // slow pulses, well above the synchroniser's minimum width
  task automatic countPulses(input int idx, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      countPinIn[idx] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      countPinIn[idx] <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask
endmodule

// file: tb/dacc_capture_compare_bench.sv
// self-checking bench for the dual array capture/compare unit
`timescale 1ns/100ps

module dacc_capture_compare_bench
  import dacc_pkg::*;
;
  logic                     ref_clk, reset, wrEn, staggered, extTimebaseEv;
  logic [5:0]               wrAddr;
  logic [TMR_W-1:0]         wrData, v1, v2;
  logic [CC_CNT*3-1:0]      ccModeFlat;
  logic [CC_CNT-1:0]        ccTimerSel, ccSingle, ccIrq;
  logic [CC_CNT*2-1:0]      ccEdgeFlat;
  logic [TMR_CNT-1:0]       tmrRun, tmrOvf;
  logic [TMR_CNT*2-1:0]     tmrSrcFlat;
  logic [TMR_CNT*3-1:0]     tmrPreFlat;
  logic [CNT_PINS-1:0]      countPinIn;
  logic [PIN_CNT-1:0]       ccPinIn, ccPinOut, ccPinOe;
  logic [CC_CNT*TMR_W-1:0]  ccValueFlat;
  logic [TMR_CNT*TMR_W-1:0] tmrValueFlat;
  int                       failures, n_checks, k;
  int                       expIrq[$];  // expected requests, oldest first

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  dacc_capture_compare u_dacc_capture_compare (
    .ref_clk, .reset, .wrEn, .wrAddr, .wrData, .ccModeFlat, .ccTimerSel,
    .ccEdgeFlat, .ccSingle, .tmrRun, .tmrSrcFlat, .tmrPreFlat, .staggered,
    .extTimebaseEv, .countPinIn, .ccPinIn, .ccPinOut, .ccPinOe, .ccIrq,
    .ccValueFlat, .tmrValueFlat, .tmrOvf
  );
  dacc_pin_model u_dacc_pin_model (
    .ref_clk, .ccPinOut, .ccPinOe, .ccPinIn, .countPinIn
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one strobe, then a low edge so two writes never merge
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    wrEn   <= 1'b1;
    wrAddr <= a;
    wrData <= d;
    @(posedge ref_clk);
    wrEn   <= 1'b0;
  endtask
  task automatic setReg(input int r, input logic [2:0] m, input logic [15:0] v);
    wr(6'(r), v);
    ccModeFlat[r*3+:3] <= m;
  endtask
  // bounded wait for a timer value, sampled once settled
  task automatic waitTmr(input int t, input logic [15:0] v);
    int n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (tmrValueFlat[t*16+:16] !== v && n < 2000);
    if (n >= 2000) chk(0, 1);
  endtask
  // every request pulse takes the oldest expectation
  always @(posedge ref_clk) begin
    #1;
    for (int i = 0; i < CC_CNT; i++) begin
      if (ccIrq[i] === 1'b1) chk(32'(i), expIrq.size() ? expIrq.pop_front() : -1);
    end
  end
  initial begin
    #400000;
    failures++;
    print_verdict;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hec6f));
    {reset, wrEn, wrAddr, wrData, staggered, extTimebaseEv} = {1'b1, 25'h0};
    {ccModeFlat, ccTimerSel, ccEdgeFlat, ccSingle} = '0;
    {tmrRun, tmrSrcFlat, tmrPreFlat} = '0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    // array one: repeatable, once per period and single event requests
    wr(ADDR_RELOAD_BASE, 16'hfff0);
    wr(ADDR_TIMER_BASE, 16'hfff0);
    setReg(0, MODE_CMP2, 16'hfff4);
    setReg(1, MODE_CMP0, 16'hfff4);
    ccSingle[2] <= 1'b1;
    setReg(2, MODE_CMP0, 16'hfff6);
    expIrq = '{0, 1, 2, 1, 0, 1};
    tmrRun[0] <= 1'b1;
    waitTmr(0, 16'hfff8);
    // rewind inside the period: only the repeatable mode fires again
    wr(ADDR_TIMER_BASE, 16'hfff2);
    waitTmr(0, 16'hfff0);
    chk(tmrOvf[0], 1);
    waitTmr(0, 16'hfffc);
    tmrRun[0] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(expIrq.size(), 0);
    ccModeFlat <= '0;
    // prescaled tick every fourth cycle, then the stagger floor of eight
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_TIMER_BASE + 6'h1, 16'h0);
      tmrPreFlat[5:3] <= 3'(2 - 2 * s);
      staggered <= s[0];
      @(posedge ref_clk);
      tmrRun[1] <= 1'b1;
      repeat (64) @(posedge ref_clk);
      tmrRun[1] <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(tmrValueFlat[31:16], s ? 8 : 16);
    end
    staggered <= 1'b0;
    // external timebase pulses, then count pin pulses
    k = $urandom_range(3, 9);
    wr(ADDR_TIMER_BASE + 6'h3, 16'h0);
    tmrSrcFlat[7:6] <= SRC_TIMEBASE;
    tmrRun[3] <= 1'b1;
    repeat (k) begin
      @(posedge ref_clk);
      extTimebaseEv <= 1'b1;
      @(posedge ref_clk);
      extTimebaseEv <= 1'b0;
    end
    repeat (2) @(posedge ref_clk);
    chk(tmrValueFlat[63:48], k);
    wr(ADDR_TIMER_BASE, 16'h0);
    wr(ADDR_TIMER_BASE + 6'h2, 16'h0);
    tmrSrcFlat[1:0] <= SRC_COUNTPIN;
    tmrSrcFlat[5:4] <= SRC_COUNTPIN;
    tmrRun <= 4'h5;
    // both count pins, a different pulse count on each
    u_dacc_pin_model.countPulses(0, k);
    u_dacc_pin_model.countPulses(1, k + 1);
    chk(tmrValueFlat[15:0], k);
    chk(tmrValueFlat[47:32], k + 1);
    tmrRun <= 4'h0;
    tmrSrcFlat[5:4] <= SRC_PRESCALE;
    // capture on pin one from a stopped timer, every edge choice
    ccModeFlat[53:51] <= MODE_CAPTURE;
    for (int e = 1; e < 4; e++) begin
      ccEdgeFlat[35:34] <= 2'(e);
      v1 = 16'($urandom);
      v2 = 16'($urandom);
      wr(ADDR_TIMER_BASE + 6'h2, v1);
      if (e[0]) expIrq.push_back(17);
      u_dacc_pin_model.setPin(1, 1'b1);
      wr(ADDR_TIMER_BASE + 6'h2, v2);
      if (e[1]) expIrq.push_back(17);
      u_dacc_pin_model.setPin(1, 1'b0);
      chk(ccValueFlat[287:272], e[1] ? v2 : v1);
    end
    // same pin, now assigned to the second timer of array two
    ccTimerSel[17] <= 1'b1;
    v1 = 16'($urandom);
    wr(ADDR_TIMER_BASE + 6'h3, v1);
    expIrq.push_back(17);
    u_dacc_pin_model.setPin(1, 1'b1);
    expIrq.push_back(17);
    u_dacc_pin_model.setPin(1, 1'b0);
    chk(ccValueFlat[287:272], v1);
    ccTimerSel[17] <= 1'b0;
    chk(expIrq.size(), 0);
    // array two pins: toggle, set until wrap, double register pair
    wr(ADDR_RELOAD_BASE + 6'h2, 16'hffe0);
    wr(ADDR_TIMER_BASE + 6'h2, 16'hffe0);
    setReg(16, MODE_CMP1, 16'hffe8);
    setReg(18, MODE_CMP3, 16'hfff8);
    setReg(19, MODE_DOUBLE, 16'hffec);
    setReg(27, MODE_DOUBLE, 16'hfff4);
    expIrq = '{16, 19, 27, 18, 16, 19, 27, 18};
    tmrRun[2] <= 1'b1;
    waitTmr(2, 16'hfffc);
    chk({ccPinOut[3:2], ccPinOut[0]}, 3'b011);
    chk(ccPinOe[3:0], 4'hd);
    waitTmr(2, 16'hffe2);
    chk(ccPinOut[2], 1'b0);
    waitTmr(2, 16'hfffc);
    chk({ccPinOut[3:2], ccPinOut[0]}, 3'b010);
    tmrRun[2] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk(expIrq.size(), 0);
    // second reset in mid-run clears timers and pins
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk({tmrValueFlat[47:32], ccPinOut}, 0);
    print_verdict;
  end
endmodule
